// *** common/pcrt_fifo_if.sv ***
// Purpose: Fill and drain sides of the word buffer
// Assumes: Single clock domain
// Notes:   Entry holds storage address above data word
`timescale 1ns/100ps

interface pcrt_fifo_if #(
    parameter int W = 51
);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;

    modport fill (output in_valid, output in_data, input in_ready);
    modport drain (input out_valid, input out_data, output out_ready);
    modport store (input in_valid, input in_data, output in_ready,
                   output out_valid, output out_data, input out_ready);
endinterface

// *** common/pcrt_pkg.sv ***
// Purpose: Shared constants for the punched card read transfer block
// Assumes: 200 MHz system clock, one microsecond tick derived from it
// Notes:   Times are kept in their printed units; tick counts derive from them

package pcrt_pkg;

    // ------------------------------------------------------------------
    // Clock and divider
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int NS_PER_US = 1000;
    localparam int US_CYCLES = NS_PER_US / CLK_PERIOD_NS;
    localparam int US_DIV_W = 8;

    // ------------------------------------------------------------------
    // Reader timing, in printed units
    // ------------------------------------------------------------------
    localparam int CARDS_PER_MIN = 250;
    localparam int MS_PER_MIN = 60000;
    localparam int US_PER_MS = 1000;
    localparam int CARD_CYCLE_MS = MS_PER_MIN / CARDS_PER_MIN;
    localparam int CMD_WAIT_MS = 55;
    localparam int WORD_LR_US = 300;
    localparam int ROW_FIRST_US = 4800;
    localparam int ROW_STEP_US = 7200;
    localparam int EOR_POINT_US = 89600;

    // Microsecond tick counts
    localparam int POS_W = 18;
    localparam logic [17:0] CYCLE_TICKS = 18'(CARD_CYCLE_MS * US_PER_MS);
    localparam logic [17:0] CMD_WAIT_TICKS = 18'(CMD_WAIT_MS * US_PER_MS);
    localparam logic [17:0] LR_TICKS = 18'(WORD_LR_US);
    localparam logic [17:0] ROW_FIRST_TICKS = 18'(ROW_FIRST_US);
    localparam logic [17:0] ROW_STEP_TICKS = 18'(ROW_STEP_US);
    localparam logic [17:0] EOR_TICKS = 18'(EOR_POINT_US);

    // ------------------------------------------------------------------
    // Card image and command layout
    // ------------------------------------------------------------------
    localparam int WORD_W = 36;
    localparam logic [4:0] CARD_WORDS = 5'h18;
    localparam int COUNT_W = 15;
    localparam int ADDR_W = 15;
    localparam int ENTRY_W = ADDR_W + WORD_W;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        PCRT_COUNT_DISCONNECT = 2'h0,
        PCRT_COUNT_PROCEED = 2'h1,
        PCRT_COUNT_TRANSFER = 2'h2,
        PCRT_RECORD_PROCEED = 2'h3
    } pcrt_cmd_t;

    typedef enum logic [2:0] {
        PCRT_IDLE = 3'b001,
        PCRT_RUN = 3'b010,
        PCRT_SUSPEND = 3'b100
    } pcrt_state_t;

endpackage

// *** src/pcrt_fifo.sv ***
// Purpose: Word buffer between card reader and storage
// Assumes: Synchronous active high reset
// Notes:   Valid and ready on both sides; full stalls the filler
`timescale 1ns/100ps

module pcrt_fifo #(
    parameter int W = 51,
    parameter int D = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    pcrt_fifo_if.store q
);
    localparam int PW = $clog2(D);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(D);
    localparam logic [PW-1:0] LAST_C = PW'(D - 1);

    logic [W-1:0] mem [D];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic nempty_q;
    logic nfull_q;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
        ptr_next = (p == LAST_C) ? '0 : PW'(p + 1'b1);
    endfunction

    assign push = q.in_valid && nfull_q;
    assign pop = nempty_q && q.out_ready;
    assign q.in_ready = nfull_q;
    assign q.out_valid = nempty_q;
    assign q.out_data = mem[rd_ptr_q];

    always_comb
    begin
        count_d = count_q;
        if (push && !pop)
        begin
            count_d = CW'(count_q + 1'b1);
        end
        else if (pop && !push)
        begin
            count_d = CW'(count_q - 1'b1);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem[wr_ptr_q] <= q.in_data;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            nempty_q <= 1'b0;
            nfull_q <= 1'b1;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= ptr_next(wr_ptr_q);
            end
            if (pop)
            begin
                rd_ptr_q <= ptr_next(rd_ptr_q);
            end
            count_q <= count_d;
            nempty_q <= (count_d != '0);
            nfull_q <= (count_d != DEPTH_C);
        end
    end
endmodule // pcrt_fifo

// *** src/pcrt_reader.sv ***
// Purpose: Card reader and its data channel moving card images to storage
// Assumes: Commands and read select come from logic on i_sys_clk
// Notes:   Brush, hopper and start key pins are synchronised first
//
// Function
// - A card is 24 words, row 9 left first through row 12 right.
// - Count-disconnect of 24 stores the whole card consecutively, then disconnects.
// - Count-disconnect below 24 stores that many, disconnects, skips the rest.
// - Count above 24 keeps reading following cards until it reaches zero.
// - Non-disconnecting count commands allow words in non-consecutive locations.
// - Record-proceed of 100 stores the card, signals end-of-record, proceeds.
// - Record-proceed of 1 stores one word, skips 23, proceeds at end-of-record.
// - Empty hopper suspends reader and channel; further selects held off.
// - Select after the last card sets end-of-file and disconnects both.
// - Continuous reading runs at 250 cards per minute.
// - Each row arrives as a 36-bit left and a 36-bit right word.
// - Count-disconnect at zero disconnects at the next transmission point.
`timescale 1ns/100ps

module pcrt_reader #(
    parameter logic [17:0] P_CYCLE_TICKS = pcrt_pkg::CYCLE_TICKS,
    parameter logic [17:0] P_CMD_WAIT_TICKS = pcrt_pkg::CMD_WAIT_TICKS,
    parameter logic [17:0] P_ROW_FIRST_TICKS = pcrt_pkg::ROW_FIRST_TICKS,
    parameter logic [17:0] P_ROW_STEP_TICKS = pcrt_pkg::ROW_STEP_TICKS,
    parameter logic [17:0] P_LR_TICKS = pcrt_pkg::LR_TICKS,
    parameter logic [17:0] P_EOR_TICKS = pcrt_pkg::EOR_TICKS
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_read_select_instr,
    input wire logic i_cmd_load,
    input wire logic [1:0] i_cmd_kind,
    input wire logic [14:0] i_cmd_count,
    input wire logic [14:0] i_cmd_addr,
    input wire logic [35:0] i_brush_left,
    input wire logic [35:0] i_brush_right,
    input wire logic i_hopper_empty,
    input wire logic i_start_key,
    input wire logic i_mem_ready,
    output logic o_mem_valid,
    output logic [14:0] o_mem_addr,
    output logic [35:0] o_mem_data,
    output logic o_busy,
    output logic o_cmd_req,
    output logic o_eor,
    output logic o_eof,
    output logic o_sel_hold,
    output logic o_cmd_late,
    output logic [3:0] o_row_step
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pcrt_pkg::pcrt_state_t state_q;
    pcrt_pkg::pcrt_cmd_t kind_q;
    logic [71:0] brush_m_q;
    logic [71:0] brush_s_q;
    logic hop_m_q;
    logic hop_s_q;
    logic key_m_q;
    logic key_s_q;
    logic key_d1_q;
    logic start_edge;
    logic [pcrt_pkg::US_DIV_W-1:0] div_q;
    logic us_tick_q;
    logic [17:0] pos_q;
    logic [4:0] widx_q;
    logic have_cmd_q;
    logic got_first_q;
    logic [14:0] cnt_q;
    logic [14:0] addr_q;
    logic last_pend_q;
    logic last_card_q;
    logic at_word;
    logic at_eor;
    logic at_end;
    logic store;
    logic stall;
    logic w_ev;
    logic e_ev;
    logic end_ev;
    logic cd_stop;
    logic sel_ok;
    logic [35:0] word_now;

    localparam logic [pcrt_pkg::US_DIV_W-1:0] DIV_LAST =
        pcrt_pkg::US_DIV_W'(pcrt_pkg::US_CYCLES - 1);

    pcrt_fifo_if #(.W(pcrt_pkg::ENTRY_W)) u_fifo_if ();

    // Transmission point of word idx within the card cycle, idx 24 is end-of-record
    function automatic logic [17:0] point_ticks(input logic [4:0] idx);
        if (idx == pcrt_pkg::CARD_WORDS)
        begin
            point_ticks = P_EOR_TICKS;
        end
        else
        begin
            point_ticks = 18'(P_ROW_FIRST_TICKS + 18'(idx[4:1]) * P_ROW_STEP_TICKS
                + (idx[0] ? P_LR_TICKS : 18'h0000));
        end
    endfunction

    function automatic logic proceeds(input pcrt_pkg::pcrt_cmd_t k);
        proceeds = (k == pcrt_pkg::PCRT_COUNT_PROCEED) || (k == pcrt_pkg::PCRT_COUNT_TRANSFER);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        brush_m_q <= {i_brush_left, i_brush_right};
        brush_s_q <= brush_m_q;
        hop_m_q <= i_hopper_empty;
        hop_s_q <= hop_m_q;
        key_m_q <= i_start_key;
        key_s_q <= key_m_q;
        key_d1_q <= key_s_q;
    end

    assign start_edge = key_s_q && !key_d1_q;

    // ------------------------------------------------------------------
    // Microsecond tick
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            div_q <= '0;
            us_tick_q <= 1'b0;
        end
        else
        begin
            div_q <= (div_q == DIV_LAST) ? '0 : pcrt_pkg::US_DIV_W'(div_q + 1'b1);
            us_tick_q <= (div_q == DIV_LAST);
        end
    end

    // ------------------------------------------------------------------
    // Card cycle events
    // ------------------------------------------------------------------
    assign at_word = (state_q == pcrt_pkg::PCRT_RUN) && (widx_q < pcrt_pkg::CARD_WORDS)
        && (pos_q == point_ticks(widx_q));
    assign at_eor = (state_q == pcrt_pkg::PCRT_RUN) && (widx_q == pcrt_pkg::CARD_WORDS)
        && (pos_q == point_ticks(widx_q));
    assign at_end = (state_q == pcrt_pkg::PCRT_RUN) && (pos_q == 18'(P_CYCLE_TICKS - 1'b1));
    assign store = have_cmd_q && (cnt_q != '0);
    assign cd_stop = have_cmd_q && (cnt_q == '0) && (kind_q == pcrt_pkg::PCRT_COUNT_DISCONNECT);
    assign stall = at_word && store && !u_fifo_if.in_ready;
    assign w_ev = us_tick_q && at_word && !stall;
    assign e_ev = us_tick_q && at_eor;
    assign end_ev = us_tick_q && at_end && !stall;
    assign sel_ok = i_read_select_instr && (state_q == pcrt_pkg::PCRT_IDLE);
    assign word_now = widx_q[0] ? brush_s_q[35:0] : brush_s_q[71:36];

    assign u_fifo_if.in_valid = us_tick_q && at_word && store;
    assign u_fifo_if.in_data = {addr_q, word_now};
    assign u_fifo_if.out_ready = i_mem_ready;
    assign o_mem_valid = u_fifo_if.out_valid;
    assign o_mem_addr = u_fifo_if.out_data[pcrt_pkg::ENTRY_W-1:pcrt_pkg::WORD_W];
    assign o_mem_data = u_fifo_if.out_data[pcrt_pkg::WORD_W-1:0];

    pcrt_fifo #(
        .W(pcrt_pkg::ENTRY_W),
        .D(pcrt_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_sys_clk),
        .i_rst(i_rst),
        .q(u_fifo_if.store)
    );

    // ------------------------------------------------------------------
    // Reader sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            state_q <= pcrt_pkg::PCRT_IDLE;
            pos_q <= '0;
            widx_q <= '0;
        end
        else
        begin
            unique case (state_q)
                pcrt_pkg::PCRT_IDLE:
                begin
                    if (sel_ok && !last_card_q)
                    begin
                        state_q <= pcrt_pkg::PCRT_RUN;
                        pos_q <= '0;
                        widx_q <= '0;
                    end
                end
                pcrt_pkg::PCRT_RUN:
                begin
                    if (w_ev && cd_stop)
                    begin
                        state_q <= pcrt_pkg::PCRT_IDLE;
                    end
                    else if (us_tick_q && !stall)
                    begin
                        pos_q <= at_end ? '0 : 18'(pos_q + 1'b1);
                        if (w_ev || e_ev)
                        begin
                            widx_q <= 5'(widx_q + 1'b1);
                        end
                        if (end_ev)
                        begin
                            widx_q <= '0;
                            if (hop_s_q)
                            begin
                                state_q <= last_pend_q ? pcrt_pkg::PCRT_IDLE
                                    : pcrt_pkg::PCRT_SUSPEND;
                            end
                        end
                    end
                end
                pcrt_pkg::PCRT_SUSPEND:
                begin
                    if (start_edge)
                    begin
                        state_q <= pcrt_pkg::PCRT_RUN;
                    end
                end
                default:
                begin
                    state_q <= pcrt_pkg::PCRT_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Active command
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            have_cmd_q <= 1'b0;
            got_first_q <= 1'b0;
            kind_q <= pcrt_pkg::PCRT_COUNT_DISCONNECT;
            cnt_q <= '0;
            addr_q <= '0;
        end
        else if (state_q == pcrt_pkg::PCRT_IDLE)
        begin
            have_cmd_q <= 1'b0;
            if (sel_ok)
            begin
                got_first_q <= 1'b0;
            end
        end
        else if (i_cmd_load)
        begin
            have_cmd_q <= 1'b1;
            got_first_q <= 1'b1;
            kind_q <= pcrt_pkg::pcrt_cmd_t'(i_cmd_kind);
            cnt_q <= i_cmd_count;
            addr_q <= i_cmd_addr;
        end
        else if (w_ev && store)
        begin
            cnt_q <= 15'(cnt_q - 1'b1);
            addr_q <= 15'(addr_q + 1'b1);
            if ((cnt_q == 15'h0001) && proceeds(kind_q))
            begin
                have_cmd_q <= 1'b0;
            end
        end
        else if (w_ev && have_cmd_q && (cnt_q == '0) && proceeds(kind_q))
        begin
            have_cmd_q <= 1'b0;
        end
        else if (e_ev && have_cmd_q && (kind_q == pcrt_pkg::PCRT_RECORD_PROCEED))
        begin
            have_cmd_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Hopper and end-of-file tracking
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            last_pend_q <= 1'b0;
            last_card_q <= 1'b0;
        end
        else
        begin
            if (!hop_s_q)
            begin
                last_pend_q <= 1'b0;
            end
            else if ((state_q == pcrt_pkg::PCRT_SUSPEND) && start_edge)
            begin
                last_pend_q <= 1'b1; // Run out the remaining cards
            end
            if (end_ev && hop_s_q && last_pend_q)
            begin
                last_card_q <= 1'b1;
            end
            else if ((state_q == pcrt_pkg::PCRT_IDLE) && !hop_s_q)
            begin
                last_card_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_busy <= 1'b0;
            o_cmd_req <= 1'b0;
            o_eor <= 1'b0;
            o_eof <= 1'b0;
            o_sel_hold <= 1'b0;
            o_cmd_late <= 1'b0;
            o_row_step <= '0;
        end
        else
        begin
            o_busy <= (state_q != pcrt_pkg::PCRT_IDLE);
            o_sel_hold <= (state_q == pcrt_pkg::PCRT_SUSPEND);
            o_cmd_req <= (state_q == pcrt_pkg::PCRT_RUN) && !have_cmd_q;
            o_eor <= e_ev && have_cmd_q && (kind_q == pcrt_pkg::PCRT_RECORD_PROCEED);
            o_row_step <= widx_q[4:1];
            if (sel_ok)
            begin
                o_eof <= last_card_q;
                o_cmd_late <= 1'b0;
            end
            else if ((state_q == pcrt_pkg::PCRT_RUN) && !got_first_q
                && (pos_q >= P_CMD_WAIT_TICKS))
            begin
                o_cmd_late <= 1'b1;
            end
        end
    end
endmodule // pcrt_reader

// *** verif/pcrt_reader_chk.sv ***
// Purpose: Port level checks on the card reader channel
// Assumes: One clock domain, synchronous active high reset
// Notes:   Attached to every reader instance by bind
`timescale 1ns/100ps

module pcrt_reader_chk (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_read_select_instr,
    input wire logic i_cmd_load,
    input wire logic i_mem_ready,
    input wire logic o_mem_valid,
    input wire logic [14:0] o_mem_addr,
    input wire logic [35:0] o_mem_data,
    input wire logic o_busy,
    input wire logic o_cmd_req,
    input wire logic o_eor,
    input wire logic o_eof,
    input wire logic o_sel_hold,
    input wire logic [3:0] o_row_step
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_eor_seen;
        o_eor;
    endsequence
    sequence s_req_back;
        ##[1:2] o_cmd_req;
    endsequence

    a_busy_from_sel: assert property ($rose(o_busy) |-> $past(i_read_select_instr, 2))
        else $error("busy rose without a select");
    a_hold_busy: assert property (o_sel_hold |-> o_busy)
        else $error("suspended but channel not busy");
    a_hold_no_sel: assert property (o_sel_hold && i_read_select_instr |=> o_busy && !o_eof)
        else $error("select not held off while suspended");
    a_eof_on_sel: assert property ($rose(o_eof) |-> !o_busy && $past(i_read_select_instr))
        else $error("end of file without select or still busy");
    a_row_order: assert property ($changed(o_row_step) |->
        (o_row_step == $past(o_row_step) + 4'h1) || (o_row_step == 4'h0))
        else $error("row position out of order");
    a_row_range: assert property (o_row_step <= 4'hc)
        else $error("row position beyond end");
    a_mem_hold: assert property (o_mem_valid && !i_mem_ready |=>
        o_mem_valid && $stable(o_mem_addr) && $stable(o_mem_data))
        else $error("stored word changed while stalled");
    a_eor_single: assert property (s_eor_seen |=> !o_eor)
        else $error("end of record longer than one cycle");
    a_eor_req: assert property (s_eor_seen |-> s_req_back)
        else $error("no command request after end of record");
    a_load_takes: assert property (o_busy && i_cmd_load |-> ##[1:2] !o_cmd_req)
        else $error("loaded command not taken");
endmodule // pcrt_reader_chk

bind pcrt_reader pcrt_reader_chk u_chk (.*);

// *** verif/pcrt_reader_tb.sv ***
// Purpose: Self-checking bench for the card reader channel
// Assumes: Shortened card timing; storage model on the word side
// Notes:   Brush words encode side and row so order is visible
`timescale 1ns/100ps

module pcrt_reader_tb;
    localparam int CYC_T = 44;
    logic clk, rst, sel, load, hop, key, stall, ready, mvalid;
    logic busy, req, eor, eof, hold, late;
    logic [1:0] kind;
    logic [14:0] cnt, adr, maddr;
    logic [35:0] bl, br, mdata;
    logic [3:0] row;
    int miscompares = 0;
    int num_checks = 0;
    int n0;

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    pcrt_reader #(.P_CYCLE_TICKS(18'(CYC_T)), .P_CMD_WAIT_TICKS(18'h2),
        .P_ROW_FIRST_TICKS(18'h4), .P_ROW_STEP_TICKS(18'h3), .P_LR_TICKS(18'h1),
        .P_EOR_TICKS(18'h28)) dut (.i_sys_clk(clk), .i_rst(rst),
        .i_read_select_instr(sel), .i_cmd_load(load), .i_cmd_kind(kind),
        .i_cmd_count(cnt), .i_cmd_addr(adr), .i_brush_left(bl), .i_brush_right(br),
        .i_hopper_empty(hop), .i_start_key(key), .i_mem_ready(ready),
        .o_mem_valid(mvalid), .o_mem_addr(maddr), .o_mem_data(mdata), .o_busy(busy),
        .o_cmd_req(req), .o_eor(eor), .o_eof(eof), .o_sel_hold(hold),
        .o_cmd_late(late), .o_row_step(row));

    pcrt_store_model mdl (.i_clk(clk), .i_valid(mvalid), .i_addr(maddr),
        .i_data(mdata), .i_stall(stall), .o_ready(ready));

    // Brushes present the row under them: left and right halves
    always @(posedge clk)
    begin
        #1;
        bl = {4'h1, 28'h000_0000, row};
        br = {4'h2, 28'h000_0000, row};
    end

    function automatic logic [35:0] exp_word(input int i);
        return {(i % 2) ? 4'h2 : 4'h1, 28'h000_0000, 4'((i % 24) / 2)};
    endfunction

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic cyc(input int n);
        repeat (n) step();
    endtask

    task automatic select();
        step();
        sel = 1'b1;
        step();
        sel = 1'b0;
    endtask

    task automatic load_cmd(input logic [1:0] k, input logic [14:0] c, input logic [14:0] a);
        step();
        kind = k;
        cnt = c;
        adr = a;
        load = 1'b1;
        step();
        load = 1'b0;
    endtask

    // Waits: 0 idle, 1 word count, 2 end of record, 3 command request, 4 hold
    task automatic wait_for(input int what, input int n);
        logic hit;
        for (int i = 0; i < 40000; i++)
        begin
            case (what)
                0: hit = !busy;
                1: hit = (mdl.n_got >= n);
                2: hit = eor;
                3: hit = req;
                default: hit = hold;
            endcase
            if (hit === 1'b1)
                return;
            step();
        end
        miscompares++;
        $display("mismatch at %0t: wait %0d ran out", $time, what);
        stop_test();
    endtask

    task automatic check_words(input int first, input int n, input logic [14:0] base,
        input int w0);
        for (int k = 0; k < n; k++)
        begin
            check(36'(mdl.got_addr[first + k]), 36'(base + 15'(k)));
            check(mdl.got_data[first + k], exp_word(w0 + k));
        end
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, miscompares);
    endtask

    task automatic t_full_card();
        n0 = mdl.n_got;
        stall = 1'b1;
        select();
        load_cmd(2'h0, 15'h18, 15'h100);
        cyc(3000);
        check(36'(mdl.n_got), 36'(n0));
        check(36'(mvalid), 36'h1);
        stall = 1'b0;
        wait_for(1, n0 + 24);
        wait_for(0, 0);
        cyc(4);
        check_words(n0, 24, 15'h100, 0);
        check(36'(mvalid), 36'h0);
        check(36'(mdl.n_got), 36'(n0 + 24));
        end_test("full_card");
    endtask

    task automatic t_short();
        n0 = mdl.n_got;
        select();
        load_cmd(2'h0, 15'h5, 15'h200);
        wait_for(1, n0 + 5);
        cyc(50);
        check(36'(busy), 36'h1);
        wait_for(0, 0);
        cyc(3000);
        check(36'(mdl.n_got), 36'(n0 + 5));
        check_words(n0, 5, 15'h200, 0);
        end_test("short");
    endtask

    task automatic t_multi();
        n0 = mdl.n_got;
        select();
        load_cmd(2'h0, 15'h1e, 15'h300);
        wait_for(1, n0 + 30);
        wait_for(0, 0);
        check_words(n0, 30, 15'h300, 0);
        check(36'(mdl.got_t[n0 + 24] - mdl.got_t[n0]), 36'(CYC_T * pcrt_pkg::US_CYCLES));
        end_test("multi");
    endtask

    task automatic t_record();
        n0 = mdl.n_got;
        select();
        load_cmd(2'h3, 15'h1, 15'h400);
        wait_for(2, 0);
        check(36'(mdl.n_got), 36'(n0 + 1));
        wait_for(3, 0);
        load_cmd(2'h3, 15'h64, 15'h500);
        wait_for(2, 0);
        check(36'(mdl.n_got), 36'(n0 + 25));
        check_words(n0, 1, 15'h400, 0);
        check_words(n0 + 1, 24, 15'h500, 0);
        wait_for(3, 0);
        load_cmd(2'h0, 15'h0, 15'h0);
        wait_for(0, 0);
        check(36'(mdl.n_got), 36'(n0 + 25));
        end_test("record");
    endtask

    task automatic t_split();
        n0 = mdl.n_got;
        select();
        load_cmd(2'h1, 15'h2, 15'h600);
        wait_for(1, n0 + 2);
        wait_for(3, 0);
        load_cmd(2'h2, 15'h2, 15'h700);
        wait_for(1, n0 + 4);
        wait_for(3, 0);
        load_cmd(2'h0, 15'h0, 15'h0);
        wait_for(0, 0);
        check_words(n0, 2, 15'h600, 0);
        check_words(n0 + 2, 2, 15'h700, 2);
        end_test("split");
    endtask

    task automatic t_late();
        n0 = mdl.n_got;
        select();
        cyc(700);
        check(36'(late), 36'h1);
        load_cmd(2'h0, 15'h0, 15'h0);
        wait_for(0, 0);
        check(36'(mdl.n_got), 36'(n0));
        end_test("late");
    endtask

    task automatic t_hopper();
        n0 = mdl.n_got;
        select();
        cyc(2);
        check(36'(late), 36'h0);
        load_cmd(2'h1, 15'h64, 15'h800);
        hop = 1'b1;
        wait_for(4, 0);
        check(36'(busy), 36'h1);
        select();
        cyc(4);
        check(36'(hold), 36'h1);
        check(36'(eof), 36'h0);
        key = 1'b1;
        cyc(4);
        key = 1'b0;
        wait_for(0, 0);
        check(36'(mdl.n_got), 36'(n0 + 48));
        select();
        cyc(2);
        check(36'(eof), 36'h1);
        check(36'(busy), 36'h0);
        hop = 1'b0;
        end_test("hopper");
    endtask

    initial
    begin
        {sel, load, hop, key, stall, kind, cnt, adr, bl, br} = '0;
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(2);
        t_full_card();
        t_short();
        t_multi();
        t_record();
        t_split();
        t_late();
        t_hopper();
        stop_test();
    end
endmodule // pcrt_reader_tb

// *** verif/pcrt_store_model.sv ***
// Purpose: Storage side model that takes words from the reader's buffer
// Assumes: Single clock; ready changes just after the rising edge
// Notes:   Logs address, data and arrival cycle of every accepted word
`timescale 1ns/100ps

module pcrt_store_model (
    input wire logic i_clk,
    input wire logic i_valid,
    input wire logic [14:0] i_addr,
    input wire logic [35:0] i_data,
    input wire logic i_stall,
    output logic o_ready
);
    logic [14:0] got_addr [$];
    logic [35:0] got_data [$];
    int got_t [$];
    int n_got = 0;
    int n_cyc = 0;

    initial o_ready = 1'b0;

    // Ready follows the stall request one edge later
    always @(posedge i_clk)
    begin
        #1;
        o_ready = !i_stall;
    end

    always @(posedge i_clk)
    begin
        n_cyc = n_cyc + 1;
        if (i_valid === 1'b1 && o_ready === 1'b1)
        begin
            got_addr.push_back(i_addr);
            got_data.push_back(i_data);
            got_t.push_back(n_cyc);
            n_got = n_got + 1;
        end
    end
endmodule // pcrt_store_model
